//--- hw/dws_regs.svh
// Register map, field positions, reset values and opcodes of the doubleword store decoder
// Overview of operation
// - Opcode 31 with extended code 149 and low bit 0 is the indexed integer doubleword store.
// - That store addresses base plus index, or the index alone when the base field is zero.
// - With the 64-bit mode off, that store raises an illegal-instruction event and stores nothing.
// - Opcode 54 is the floating double store with source, base and 16-bit displacement fields.
// - The displacement is sign-extended to 32 bits and added to the base, or used alone on zero.
// - Every floating double store writes the full 64-bit source register unconverted.
// - None of these stores touches floating status or condition field 0; there is one form.
// - Opcode 55 is the floating double store with base update, with the displacement layout.
// - Update forms write the address back only for a nonzero base and a fault-free access.
// - Opcode 31 with extended code 759 is the indexed floating double store with update.
// - Opcode 31 with extended code 727 is the indexed floating double store without update.
// - Indexed floating stores address base plus index, or the index alone on a zero base.
// - An integer doubleword store with update and a zero base field is an invalid form.
`ifndef DWS_REGS_SVH
`define DWS_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DWS_CTRL_OFS 8'h00
`define DWS_INSTR_OFS 8'h04
`define DWS_BASE_OFS 8'h08
`define DWS_INDEX_OFS 8'h0c
`define DWS_SRC_LO_OFS 8'h10
`define DWS_SRC_HI_OFS 8'h14
`define DWS_STAT_OFS 8'h18
`define DWS_MASK_OFS 8'h1c
`define DWS_EA_OFS 8'h20
`define DWS_DEC_OFS 8'h24

// ****************************************
// Fields and reset values
// ****************************************
`define DWS_CTRL_MODE64_BIT 0
`define DWS_CTRL_RST 32'h0000_0001
`define DWS_ST_DONE 0
`define DWS_ST_ILLEGAL 1
`define DWS_ST_BADFORM 2
`define DWS_ST_PASSED 3
`define DWS_ST_FAULT 4
`define DWS_ST_WBACK 5
`define DWS_ST_W 6

// ****************************************
// Opcodes
// ****************************************
`define DWS_OP_X 6'd31
`define DWS_OP_FP_DISP 6'd54
`define DWS_OP_FP_DISP_UPD 6'd55
`define DWS_XO_INT_IDX 10'd149
`define DWS_XO_INT_IDX_UPD 10'd181
`define DWS_XO_FP_IDX_UPD 10'd759
`define DWS_XO_FP_IDX 10'd727

`endif

//--- hw/dws_pkg.sv
// Types shared by the doubleword store decoder modules
package dws_pkg;
  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_INT_IDX = 3'b001,
    K_FP_DISP = 3'b010,
    K_FP_DISP_UPD = 3'b011,
    K_FP_IDX_UPD = 3'b100,
    K_FP_IDX = 3'b101,
    K_BAD_FORM = 3'b110
  } kind_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DECODE = 3'b001,
    S_ISSUE = 3'b010,
    S_WAIT = 3'b011
  } state_t;
endpackage

//--- hw/dws_dec_if.sv
// Decode results passed between the field decoder, the address adder and the top
interface dws_dec_if;
  import dws_pkg::*;
  logic [31:0] instr;
  logic [31:0] base_val;
  logic [31:0] index_val;
  kind_t kind;
  logic [4:0] int_source_field;
  logic [4:0] fp_source_field;
  logic [4:0] base_reg_field;
  logic [4:0] index_reg_field;
  logic [15:0] disp;
  logic base_zero;
  logic use_disp;
  logic [31:0] ea;
  modport dec (input instr, output kind, int_source_field, fp_source_field, base_reg_field,
               index_reg_field, disp, base_zero, use_disp);
  modport calc (input base_val, index_val, disp, base_zero, use_disp, output ea);
  modport top (output instr, base_val, index_val, input kind, int_source_field, fp_source_field,
               base_reg_field, index_reg_field, disp, base_zero, use_disp, ea);
endinterface

//--- hw/dws_field_decode.sv
// Opcode recognition and field extraction for the doubleword stores
`include "dws_regs.svh"
module dws_field_decode (
  // Decode results
  dws_dec_if.dec d
);
  import dws_pkg::*;
  logic [5:0] opcode;
  logic [9:0] xop;

  // Bit 31 of the instruction is the most significant bit
  assign opcode = d.instr[31:26];
  assign xop = d.instr[10:1];
  assign d.int_source_field = d.instr[25:21];
  assign d.fp_source_field = d.instr[25:21];
  assign d.base_reg_field = d.instr[20:16];
  assign d.index_reg_field = d.instr[15:11];
  assign d.disp = d.instr[15:0];
  assign d.base_zero = (d.instr[20:16] == 5'h00);
  assign d.use_disp = (opcode == `DWS_OP_FP_DISP) || (opcode == `DWS_OP_FP_DISP_UPD);

  always_comb begin
    d.kind = K_NONE;
    case (opcode)
      `DWS_OP_FP_DISP: d.kind = K_FP_DISP;
      `DWS_OP_FP_DISP_UPD: d.kind = K_FP_DISP_UPD;
      `DWS_OP_X: begin
        if (xop == `DWS_XO_INT_IDX && !d.instr[0]) begin
          d.kind = K_INT_IDX;
        end else if (xop == `DWS_XO_INT_IDX_UPD && !d.instr[0] && d.base_zero) begin
          d.kind = K_BAD_FORM;
        end else if (xop == `DWS_XO_FP_IDX_UPD) begin
          d.kind = K_FP_IDX_UPD;
        end else if (xop == `DWS_XO_FP_IDX) begin
          d.kind = K_FP_IDX;
        end else begin
          d.kind = K_NONE;
        end
      end
      default: d.kind = K_NONE;
    endcase
  end
endmodule

//--- hw/dws_ea_adder.sv
// Effective address adder: base or zero, plus displacement or index
module dws_ea_adder (
  // Operands and result
  dws_dec_if.calc c
);
  logic [31:0] base_term;
  logic [31:0] off_term;

  assign base_term = c.base_zero ? 32'h0000_0000 : c.base_val;
  assign off_term = c.use_disp ? {{16{c.disp[15]}}, c.disp} : c.index_val;
  assign c.ea = base_term + off_term;
endmodule

//--- hw/doubleword_store_decode.sv
// Doubleword store decoder with AHB-Lite register access and store issue
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`include "dws_regs.svh"
module doubleword_store_decode (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Store request to the data access path
  output logic store_valid,
  input wire logic store_ready,
  output logic [31:0] store_addr,
  output logic [63:0] store_data,
  output logic [4:0] store_src_sel,
  output logic store_src_fp,
  // Access completion
  input wire logic acc_done,
  input wire logic acc_align_fault,
  input wire logic acc_dsi_fault,
  // Base register write back
  output logic wb_valid,
  output logic [4:0] wb_reg,
  output logic [31:0] wb_data,
  // Pass-on and exception
  output logic passed_on,
  output logic illegal_instr,
  // Interrupt
  output logic irq
);
  import dws_pkg::*;

  dws_dec_if dif ();

  // ****************************************
  // Decoder and adder
  // ****************************************
  dws_field_decode u_dec (
    .d(dif)
  );

  dws_ea_adder u_add (
    .c(dif)
  );

  // ****************************************
  // Register state
  // ****************************************
  logic [31:0] ctrl_r;
  logic [31:0] instr_r;
  logic [31:0] base_val_r;
  logic [31:0] index_val_r;
  logic [31:0] src_lo_r;
  logic [31:0] src_hi_r;
  logic [`DWS_ST_W-1:0] status_r;
  logic [`DWS_ST_W-1:0] status_nxt;
  logic [`DWS_ST_W-1:0] mask_r;
  logic [`DWS_ST_W-1:0] mask_nxt;
  logic [31:0] ea_r;
  kind_t kind_r;
  logic [4:0] src_sel_r;
  logic [4:0] base_sel_r;
  logic [4:0] index_sel_r;
  logic base_zero_r;
  logic [`DWS_ST_W-1:0] ev;
  state_t state_r;
  state_t state_nxt;

  // ****************************************
  // AHB-Lite address and data phase
  // ****************************************
  logic addr_ok;
  logic wr_pend_r;
  logic [7:0] wr_ofs_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic stat_rd;
  logic [7:0] ofs;

  assign addr_ok = hsel && htrans[1] && hready;
  assign ofs = haddr[7:0];
  assign stat_rd = addr_ok && !hwrite && (ofs == `DWS_STAT_OFS) && (haddr[31:8] == 24'h000000);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
      wr_ofs_r <= ofs;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ofs)
      `DWS_CTRL_OFS: rd_mux = ctrl_r;
      `DWS_INSTR_OFS: rd_mux = instr_r;
      `DWS_BASE_OFS: rd_mux = base_val_r;
      `DWS_INDEX_OFS: rd_mux = index_val_r;
      `DWS_SRC_LO_OFS: rd_mux = src_lo_r;
      `DWS_SRC_HI_OFS: rd_mux = src_hi_r;
      `DWS_STAT_OFS: rd_mux = {{(32-`DWS_ST_W){1'b0}}, status_r};
      `DWS_MASK_OFS: rd_mux = {{(32-`DWS_ST_W){1'b0}}, mask_r};
      `DWS_EA_OFS: rd_mux = ea_r;
      `DWS_DEC_OFS: rd_mux = {10'h000, (state_r != S_IDLE), kind_r, src_sel_r, base_sel_r,
                              index_sel_r, base_zero_r, 2'b00};
      default: rd_mux = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h000000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Read data captured in the address phase so it stands in the data phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      rdata_r <= rd_mux;
    end
  end

  // ****************************************
  // Software-written registers
  // ****************************************
  logic instr_wr;
  assign instr_wr = wr_pend_r && (wr_ofs_r == `DWS_INSTR_OFS) && (state_r == S_IDLE);

  // New mask also feeds the interrupt, so a mask write takes effect at once
  always_comb begin
    mask_nxt = mask_r;
    if (wr_pend_r && (wr_ofs_r == `DWS_MASK_OFS)) begin
      mask_nxt = hwdata[`DWS_ST_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= `DWS_CTRL_RST;
    end else if (wr_pend_r && (wr_ofs_r == `DWS_CTRL_OFS)) begin
      ctrl_r <= {31'h0000_0000, hwdata[`DWS_CTRL_MODE64_BIT]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_r <= {`DWS_ST_W{1'b0}};
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // Operand registers are frozen while an instruction is in flight
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      instr_r <= 32'h0000_0000;
      base_val_r <= 32'h0000_0000;
      index_val_r <= 32'h0000_0000;
      src_lo_r <= 32'h0000_0000;
      src_hi_r <= 32'h0000_0000;
    end else if (wr_pend_r && state_r == S_IDLE) begin
      case (wr_ofs_r)
        `DWS_INSTR_OFS: instr_r <= hwdata;
        `DWS_BASE_OFS: base_val_r <= hwdata;
        `DWS_INDEX_OFS: index_val_r <= hwdata;
        `DWS_SRC_LO_OFS: src_lo_r <= hwdata;
        `DWS_SRC_HI_OFS: src_hi_r <= hwdata;
        default: instr_r <= instr_r;
      endcase
    end
  end

  assign dif.instr = instr_r;
  assign dif.base_val = base_val_r;
  assign dif.index_val = index_val_r;

  // ****************************************
  // Sequencer
  // ****************************************
  logic is_update;
  logic fault;
  assign is_update = (kind_r == K_FP_DISP_UPD) || (kind_r == K_FP_IDX_UPD);
  assign fault = acc_align_fault || acc_dsi_fault;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (instr_wr) begin
          state_nxt = S_DECODE;
        end
      end
      S_DECODE: begin
        case (dif.kind)
          K_NONE: state_nxt = S_IDLE;
          K_BAD_FORM: state_nxt = S_IDLE;
          K_INT_IDX: state_nxt = ctrl_r[`DWS_CTRL_MODE64_BIT] ? S_ISSUE : S_IDLE;
          default: state_nxt = S_ISSUE;
        endcase
      end
      S_ISSUE: begin
        if (store_ready) begin
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (acc_done) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Decode results and address held for the whole access
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      kind_r <= K_NONE;
      ea_r <= 32'h0000_0000;
      src_sel_r <= 5'h00;
      base_sel_r <= 5'h00;
      index_sel_r <= 5'h00;
      base_zero_r <= 1'b1;
    end else if (state_r == S_DECODE) begin
      kind_r <= dif.kind;
      ea_r <= dif.ea;
      src_sel_r <= (dif.kind == K_INT_IDX) ? dif.int_source_field : dif.fp_source_field;
      base_sel_r <= dif.base_reg_field;
      index_sel_r <= dif.index_reg_field;
      base_zero_r <= dif.base_zero;
    end
  end

  // ****************************************
  // Store request
  // ****************************************
  assign store_valid = (state_r == S_ISSUE);
  assign store_addr = ea_r;
  assign store_data = {src_hi_r, src_lo_r};
  assign store_src_sel = src_sel_r;
  assign store_src_fp = (kind_r != K_INT_IDX);
  // no status or condition outputs exist, so neither can change

  // ****************************************
  // Write back and one-cycle events
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_valid <= 1'b0;
    end else begin
      wb_valid <= (state_r == S_WAIT) && acc_done && is_update && !base_zero_r && !fault;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_reg <= 5'h00;
      wb_data <= 32'h0000_0000;
    end else if ((state_r == S_WAIT) && acc_done) begin
      wb_reg <= base_sel_r;
      wb_data <= ea_r;
    end
  end

  always_comb begin
    ev = {`DWS_ST_W{1'b0}};
    if (state_r == S_DECODE) begin
      ev[`DWS_ST_PASSED] = (dif.kind == K_NONE);
      ev[`DWS_ST_BADFORM] = (dif.kind == K_BAD_FORM);
      ev[`DWS_ST_ILLEGAL] = (dif.kind == K_INT_IDX) && !ctrl_r[`DWS_CTRL_MODE64_BIT];
    end
    if (state_r == S_WAIT && acc_done) begin
      ev[`DWS_ST_DONE] = !fault;
      ev[`DWS_ST_FAULT] = fault;
      ev[`DWS_ST_WBACK] = is_update && !base_zero_r && !fault;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      passed_on <= 1'b0;
    end else begin
      passed_on <= ev[`DWS_ST_PASSED];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      illegal_instr <= 1'b0;
    end else begin
      illegal_instr <= ev[`DWS_ST_ILLEGAL];
    end
  end

  // ****************************************
  // Sticky status, read to clear, masked interrupt
  // ****************************************
  always_comb begin
    status_nxt = status_r;
    if (stat_rd) begin
      status_nxt = {`DWS_ST_W{1'b0}};
    end
    status_nxt = status_nxt | ev;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_r <= {`DWS_ST_W{1'b0}};
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_nxt & mask_nxt);
    end
  end

  logic [2:0] unused_hsize;
  assign unused_hsize = hsize;
endmodule

//--- tb/dws_access_model.sv
// Behavioural data access path answering store requests
module dws_access_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request side
  input wire logic store_valid,
  output logic store_ready,
  // Stall length and fault choice from the bench
  input wire logic [1:0] slow,
  input wire logic [1:0] fault,
  // Completion
  output logic acc_done,
  output logic acc_align_fault,
  output logic acc_dsi_fault
);
  logic [1:0] cnt_r;
  logic pend_r;
  // ****
  // Accept after a stall, complete two cycles later
  // ****
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      store_ready <= 1'b0;
      cnt_r <= 2'b00;
      pend_r <= 1'b0;
    end else begin
      store_ready <= store_valid && !store_ready && cnt_r == slow;
      cnt_r <= (store_valid && !store_ready && cnt_r != slow) ? cnt_r + 2'b01 : 2'b00;
      pend_r <= store_valid && store_ready;
    end
  end
  always_ff @(posedge sys_clk) begin
    acc_done <= !rst && pend_r;
    acc_align_fault <= !rst && pend_r && fault[0];
    acc_dsi_fault <= !rst && pend_r && fault[1];
  end
endmodule

//--- tb/doubleword_store_decode_sva.sv
// Assertions on the store issue and write-back ports of the decoder
module dws_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Observed ports
  input wire logic store_valid,
  input wire logic store_ready,
  input wire logic [31:0] store_addr,
  input wire logic [63:0] store_data,
  input wire logic acc_done,
  input wire logic acc_align_fault,
  input wire logic acc_dsi_fault,
  input wire logic wb_valid,
  input wire logic [4:0] wb_reg,
  input wire logic [31:0] wb_data,
  input wire logic passed_on,
  input wire logic illegal_instr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_store_held: assert property (store_valid && !store_ready |=>
    store_valid && $stable(store_addr) && $stable(store_data)) else $error("store request lost");
  a_store_once: assert property (store_valid && store_ready |=> !store_valid)
    else $error("store issued twice");
  a_wb_after_ok: assert property (wb_valid |->
    $past(acc_done) && !$past(acc_align_fault) && !$past(acc_dsi_fault))
    else $error("write-back without ok");
  a_wb_target: assert property (wb_valid |-> wb_reg != 5'h00 && wb_data == store_addr)
    else $error("write-back target wrong");
  a_fault_no_wb: assert property (acc_done && (acc_align_fault || acc_dsi_fault) |=>
    !wb_valid) else $error("write-back after fault");
  a_wb_single: assert property (wb_valid |=> !wb_valid)
    else $error("write-back pulse too long");
  a_illegal_quiet: assert property (illegal_instr |-> !store_valid ##1 !store_valid)
    else $error("store with illegal instruction");
  a_pass_quiet: assert property (passed_on |-> !store_valid && !illegal_instr && !wb_valid)
    else $error("unclaimed code acted on");
  a_pass_single: assert property (passed_on |=> !passed_on)
    else $error("pass-on pulse too long");
  c_wb: cover property (wb_valid);
  c_illegal: cover property (illegal_instr);
  c_pass: cover property (passed_on);
endmodule

bind doubleword_store_decode dws_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .store_valid(store_valid), .store_ready(store_ready), .store_addr(store_addr),
  .store_data(store_data), .acc_done(acc_done), .acc_align_fault(acc_align_fault),
  .acc_dsi_fault(acc_dsi_fault), .wb_valid(wb_valid), .wb_reg(wb_reg), .wb_data(wb_data),
  .passed_on(passed_on), .illegal_instr(illegal_instr));

//--- tb/tb.sv
// Self-checking bench: register access, store issue and write-back of the decoder
`include "dws_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CTL = {24'h0, `DWS_CTRL_OFS};
  localparam logic [31:0] A_INS = {24'h0, `DWS_INSTR_OFS};
  localparam logic [31:0] A_BAS = {24'h0, `DWS_BASE_OFS};
  localparam logic [31:0] A_IDX = {24'h0, `DWS_INDEX_OFS};
  localparam logic [31:0] A_SLO = {24'h0, `DWS_SRC_LO_OFS};
  localparam logic [31:0] A_SHI = {24'h0, `DWS_SRC_HI_OFS};
  localparam logic [31:0] A_STA = {24'h0, `DWS_STAT_OFS};
  localparam logic [31:0] A_MSK = {24'h0, `DWS_MASK_OFS};
  localparam logic [31:0] A_EA = {24'h0, `DWS_EA_OFS};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] slow = 2'h0;
  logic [1:0] fault = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, store_valid, store_ready, store_src_fp, acc_done, irq_q;
  logic acc_align_fault, acc_dsi_fault, wb_valid, passed_on, illegal_instr, irq, c_fp;
  logic [31:0] hrdata, store_addr, wb_data, c_addr, c_wd, rv;
  logic [63:0] store_data, c_data;
  logic [4:0] store_src_sel, wb_reg, c_sel, c_wr;
  int n_fail = 0;
  int checked = 0;
  int n_st = 0;
  int n_wb = 0;
  int n_irq = 0;
  int n_pass = 0;
  int n_ill = 0;
  always #10 sys_clk = ~sys_clk;
  doubleword_store_decode DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .store_valid(store_valid),
    .store_ready(store_ready), .store_addr(store_addr), .store_data(store_data),
    .store_src_sel(store_src_sel), .store_src_fp(store_src_fp), .acc_done(acc_done),
    .acc_align_fault(acc_align_fault), .acc_dsi_fault(acc_dsi_fault), .wb_valid(wb_valid),
    .wb_reg(wb_reg), .wb_data(wb_data), .passed_on(passed_on), .illegal_instr(illegal_instr),
    .irq(irq));
  dws_access_model acc (.sys_clk(sys_clk), .rst(rst), .store_valid(store_valid),
    .store_ready(store_ready), .slow(slow), .fault(fault), .acc_done(acc_done),
    .acc_align_fault(acc_align_fault), .acc_dsi_fault(acc_dsi_fault));
  // ****
  // Capture of stores, write-backs and interrupt edges
  // ****
  always @(posedge sys_clk) begin
    if (store_valid === 1'b1 && store_ready === 1'b1) begin
      n_st++;
      {c_addr, c_data, c_sel, c_fp} = {store_addr, store_data, store_src_sel, store_src_fp};
    end
    if (wb_valid === 1'b1) begin
      n_wb++;
      {c_wr, c_wd} = {wb_reg, wb_data};
    end
    if (passed_on === 1'b1) n_pass++;
    if (illegal_instr === 1'b1) n_ill++;
    if (irq === 1'b1 && irq_q !== 1'b1) n_irq++;
    irq_q = irq;
  end
  task wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdy;
    int i;
    i = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        n_fail++;
        wrap_up;
      end
      @(posedge sys_clk);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
    chk(hresp, 1'b0);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  function automatic logic [31:0] xi(logic [9:0] xo, logic [4:0] ra, logic b0);
    return {6'd31, 5'd7, ra, 5'd9, xo, b0};
  endfunction
  function automatic logic [31:0] di(logic [5:0] op, logic [4:0] ra, logic [15:0] d);
    return {op, 5'd12, ra, d};
  endfunction
  // ****
  // One instruction: load operands, start, poll status, compare
  // ****
  task run(input logic [31:0] ins, b, ea, input logic [7:0] st, input logic s, w);
    int i;
    int s0;
    int w0;
    int p0;
    int l0;
    logic [31:0] r;
    s0 = n_st;
    w0 = n_wb;
    p0 = n_pass;
    l0 = n_ill;
    slow <= slow + 2'h1;
    wr(A_BAS, b);
    wr(A_IDX, 32'h24);
    wr(A_SLO, ~ins);
    wr(A_SHI, ins);
    wr(A_INS, ins);
    i = 0;
    r = 32'h0;
    while (r === 32'h0 && i < 40) begin
      ahb(1'b0, A_STA, 32'h0, r);
      i++;
    end
    @(posedge sys_clk);
    chk(r, st);
    chk(irq, 1'b0);
    chk(64'(n_st - s0), s);
    chk(64'(n_pass - p0), st[3]);
    chk(64'(n_ill - l0), st[1]);
    if (s) begin
      chk(c_addr, ea);
      chk(c_data, {ins, ~ins});
      chk({c_fp, c_sel}, {ins[31:26] != 6'd31 || ins[10:1] != 10'd149, ins[25:21]});
      ahb(1'b0, A_EA, 32'h0, r);
      chk(r, ea);
    end
    chk(64'(n_wb - w0), w);
    if (w) chk({c_wr, c_wd}, {ins[20:16], ea});
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    ahb(1'b0, A_CTL, 32'h0, rv);
    chk(rv, 32'h1);
    ahb(1'b0, 32'h100, 32'h0, rv);
    chk(rv, 32'h0);
    wr(A_MSK, 32'h1);
    run(xi(10'd149, 5'd3, 1'b0), 32'h1000, 32'h1024, 8'h01, 1, 0);
    run(xi(10'd149, 5'd0, 1'b0), 32'h1000, 32'h24, 8'h01, 1, 0);
    run(di(6'd54, 5'd2, 16'hfff0), 32'h1000, 32'h0ff0, 8'h01, 1, 0);
    run(di(6'd54, 5'd0, 16'h8000), 32'h1000, 32'hffff_8000, 8'h01, 1, 0);
    run(di(6'd55, 5'd4, 16'h0010), 32'h2000, 32'h2010, 8'h21, 1, 1);
    run(di(6'd55, 5'd0, 16'h0010), 32'h2000, 32'h10, 8'h01, 1, 0);
    run(xi(10'd759, 5'd5, 1'b1), 32'h300, 32'h324, 8'h21, 1, 1);
    run(xi(10'd727, 5'd0, 1'b0), 32'h300, 32'h24, 8'h01, 1, 0);
    fault <= 2'h1;
    run(xi(10'd759, 5'd6, 1'b0), 32'h300, 32'h324, 8'h10, 1, 0);
    fault <= 2'h2;
    run(di(6'd55, 5'd6, 16'h0008), 32'h300, 32'h308, 8'h10, 1, 0);
    fault <= 2'h0;
    run(xi(10'd181, 5'd0, 1'b0), 32'h300, 32'h0, 8'h04, 0, 0);
    run(xi(10'd181, 5'd1, 1'b0), 32'h300, 32'h0, 8'h08, 0, 0);
    run(xi(10'd150, 5'd3, 1'b0), 32'h300, 32'h0, 8'h08, 0, 0);
    run(xi(10'd149, 5'd3, 1'b1), 32'h300, 32'h0, 8'h08, 0, 0);
    wr(A_CTL, 32'h0);
    run(xi(10'd149, 5'd3, 1'b0), 32'h300, 32'h0, 8'h02, 0, 0);
    wr(A_CTL, 32'h1);
    chk(n_irq, 8);
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    wrap_up;
  end
endmodule
